// File: include/ied_regs.svh
// Register offsets, field positions and reset values of the in endpoint descriptor.
`ifndef IED_REGS_SVH
`define IED_REGS_SVH
`define IED_OFS_Y_CNT     8'h00
`define IED_OFS_Y_BASE    8'h04
`define IED_OFS_X_CNT     8'h08
`define IED_OFS_CFG       8'h0c
`define IED_OFS_STATUS    8'h10
`define IED_NAK_BIT       7
`define IED_CNT_RST       8'h80
`define IED_BASE_RST      8'h00
`define IED_CFG_RST       8'h00
`define IED_CFG_EN_BIT    7
`define IED_CFG_ISO_BIT   6
`define IED_CFG_DBL_BIT   5
`define IED_LEN_UNIT_SH   3
`define IED_ADDR_LOW_ZERO 3'h0
`endif

// File: include/ied_pkg.sv
// Types shared by the in endpoint descriptor block.
package ied_pkg;
    typedef struct packed {
        logic        valid;
        logic        from_second;
        logic [12:0] byte_count;
        logic [10:0] start_addr;
        logic [10:0] length;
    } ied_send_t;
    typedef enum logic [1:0] {
        IED_IDLE = 2'b00,
        IED_SEND = 2'b01,
        IED_NAK  = 2'b10
    } ied_reply_t;
endpackage

// File: verilog/ied_desc.sv
// In endpoint descriptor registers and the send-or-NACK decision for one endpoint.
`timescale 1ns/1ps
`include "ied_regs.svh"
module ied_desc
    import ied_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        in_token_i,
    input  wire logic        in_done_i,
    input  wire logic [10:0] first_buffer_start_i,
    input  wire logic [7:0]  buffer_length_field_i,
    input  wire logic [4:0]  sample_size_field_i,
    output ied_reply_t       reply_o,
    output ied_send_t        send_o
);
    logic [7:0] ycnt_r, ycnt_nxt, ybase_r, ybase_nxt, xcnt_r, xcnt_nxt, cfg_r, cfg_nxt;
    logic       use_y_r, use_y_nxt;
    logic       busy_r, busy_nxt;
    ied_reply_t reply_r, reply_nxt;
    ied_send_t  send_r, send_nxt;
    logic [31:0] rdat_nxt;
    logic        ack_nxt;
    logic        wr, en, iso, dbl, cur_y, cur_nak, en_dly_r;
    logic [6:0]  cur_cnt;
    logic [5:0]  sample_size;

    assign en   = cfg_r[`IED_CFG_EN_BIT];
    assign iso  = cfg_r[`IED_CFG_ISO_BIT];
    assign dbl  = cfg_r[`IED_CFG_DBL_BIT];
    assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign cur_y   = dbl && use_y_r;
    assign cur_nak = cur_y ? ycnt_r[`IED_NAK_BIT] : xcnt_r[`IED_NAK_BIT];
    assign cur_cnt = cur_y ? ycnt_r[6:0] : xcnt_r[6:0];
    assign sample_size = {1'b0, sample_size_field_i} + 6'h01;

    always_comb begin
        ycnt_nxt  = ycnt_r;
        ybase_nxt = ybase_r;
        xcnt_nxt  = xcnt_r;
        cfg_nxt   = cfg_r;
        use_y_nxt = use_y_r;
        busy_nxt  = busy_r;
        reply_nxt = IED_IDLE;
        send_nxt  = send_r;
        send_nxt.valid = 1'b0;
        ack_nxt   = wb_cyc_i && wb_stb_i && !wb_ack_o;
        rdat_nxt  = 32'h00000000;
        case (wb_adr_i)
            `IED_OFS_Y_CNT:  rdat_nxt = {24'h000000, ycnt_r};
            `IED_OFS_Y_BASE: rdat_nxt = {24'h000000, ybase_r};
            `IED_OFS_X_CNT:  rdat_nxt = {24'h000000, xcnt_r};
            `IED_OFS_CFG:    rdat_nxt = {24'h000000, cfg_r};
            `IED_OFS_STATUS: rdat_nxt = {30'h0, busy_r, cur_y};
            default:         rdat_nxt = 32'h00000000;
        endcase
        if (wr) begin
            case (wb_adr_i)
                `IED_OFS_Y_CNT:  ycnt_nxt  = wb_dat_i[7:0];
                `IED_OFS_Y_BASE: ybase_nxt = wb_dat_i[7:0];
                `IED_OFS_X_CNT:  xcnt_nxt  = wb_dat_i[7:0];
                `IED_OFS_CFG:    cfg_nxt   = wb_dat_i[7:0];
                default:         cfg_nxt   = cfg_r;
            endcase
        end
        // A token in the cycle the enable rises is ignored, so the pointer restarts cleanly.
        if (!en || (en && !en_dly_r)) begin
            use_y_nxt = 1'b0;
            busy_nxt  = 1'b0;
        end else if (in_token_i && !busy_r) begin
            if (!cur_nak || iso) begin
                reply_nxt = IED_SEND;
                busy_nxt  = 1'b1;
                send_nxt.valid       = 1'b1;
                send_nxt.from_second = cur_y;
                // Widen both factors; their bare product would keep only seven bits.
                send_nxt.byte_count  = iso ? 13'(cur_cnt) * 13'(sample_size)
                                           : {6'h00, cur_cnt};
                send_nxt.start_addr  = cur_y ? {ybase_r, `IED_ADDR_LOW_ZERO}
                                             : first_buffer_start_i;
                send_nxt.length = {buffer_length_field_i, 3'h0};
            end else begin
                reply_nxt = IED_NAK;
            end
        end else if (in_done_i && busy_r) begin
            busy_nxt = 1'b0;
            // The set is applied after the bus write so a same-cycle clear loses.
            if (send_r.from_second) begin
                ycnt_nxt[`IED_NAK_BIT] = 1'b1;
            end else begin
                xcnt_nxt[`IED_NAK_BIT] = 1'b1;
            end
            if (dbl) begin
                use_y_nxt = !send_r.from_second;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ycnt_r   <= `IED_CNT_RST;
            ybase_r  <= `IED_BASE_RST;
            xcnt_r   <= `IED_CNT_RST;
            cfg_r    <= `IED_CFG_RST;
            use_y_r  <= 1'b0;
            busy_r   <= 1'b0;
            en_dly_r <= 1'b0;
            reply_r  <= IED_IDLE;
            send_r   <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ycnt_r   <= ycnt_nxt;
            ybase_r  <= ybase_nxt;
            xcnt_r   <= xcnt_nxt;
            cfg_r    <= cfg_nxt;
            use_y_r  <= use_y_nxt;
            busy_r   <= busy_nxt;
            en_dly_r <= en;
            reply_r  <= reply_nxt;
            send_r   <= send_nxt;
            wb_ack_o <= ack_nxt;
            wb_dat_o <= rdat_nxt;
        end
    end

    assign reply_o = reply_r;
    assign send_o  = send_r;

    property p_nak_reply;
        @(posedge clk_i) disable iff (rst_i)
        (en && en_dly_r && in_token_i && !busy_r && cur_nak && !iso) |=> (reply_o == IED_NAK);
    endproperty
    a_nak_reply: assert property (p_nak_reply) else $error("NACK not given.");

    property p_iso_never_nak;
        @(posedge clk_i) disable iff (rst_i)
        iso |=> (reply_o != IED_NAK);
    endproperty
    a_iso_never_nak: assert property (p_iso_never_nak) else $error("Isochronous NACK.");

    property p_x_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        (en && en_dly_r && in_done_i && busy_r && !send_r.from_second)
            |=> xcnt_r[`IED_NAK_BIT];
    endproperty
    a_x_flag_set: assert property (p_x_flag_set) else $error("First flag not set.");

    property p_y_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        (en && en_dly_r && in_done_i && busy_r && send_r.from_second)
            |=> ycnt_r[`IED_NAK_BIT];
    endproperty
    a_y_flag_set: assert property (p_y_flag_set) else $error("Second flag not set.");

    property p_single_x;
        @(posedge clk_i) disable iff (rst_i)
        (send_o.valid && !$past(dbl)) |-> !send_o.from_second;
    endproperty
    a_single_x: assert property (p_single_x) else $error("Single mode used second.");

    property p_addr_low;
        @(posedge clk_i) disable iff (rst_i)
        (send_o.valid && send_o.from_second) |-> (send_o.start_addr[2:0] == 3'h0);
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("Start address low bits set.");

    property p_len_unit;
        @(posedge clk_i) disable iff (rst_i)
        send_o.valid |-> (send_o.length == {$past(buffer_length_field_i), 3'h0});
    endproperty
    a_len_unit: assert property (p_len_unit) else $error("Length not in 8 byte units.");

    property p_iso_bytes;
        @(posedge clk_i) disable iff (rst_i)
        (send_o.valid && $past(iso)) |->
            (send_o.byte_count == 13'($past(cur_cnt))
                                  * 13'($past(sample_size_field_i) + 6'h01));
    endproperty
    a_iso_bytes: assert property (p_iso_bytes) else $error("Sample conversion wrong.");

    property p_alternate;
        @(posedge clk_i) disable iff (rst_i)
        (in_done_i && busy_r && dbl && en && en_dly_r)
            |=> (use_y_r != $past(send_r.from_second));
    endproperty
    a_alternate: assert property (p_alternate) else $error("Buffers did not alternate.");

    sequence s_iso_token;
        en && en_dly_r && in_token_i && !busy_r && iso;
    endsequence

    sequence s_plain_token;
        en && en_dly_r && in_token_i && !busy_r && !cur_nak && !iso;
    endsequence

    sequence s_enable_edge;
        en && !en_dly_r;
    endsequence

    property p_iso_sends;
        @(posedge clk_i) disable iff (rst_i)
        s_iso_token |=> ((reply_o == IED_SEND) && send_o.valid);
    endproperty
    a_iso_sends: assert property (p_iso_sends) else $error("Isochronous not served.");

    property p_plain_count;
        @(posedge clk_i) disable iff (rst_i)
        s_plain_token |=> (send_o.valid && (send_o.byte_count == {6'h00, $past(cur_cnt)}));
    endproperty
    a_plain_count: assert property (p_plain_count) else $error("Count misused.");

    property p_restart_first;
        @(posedge clk_i) disable iff (rst_i)
        s_enable_edge |=> !use_y_r;
    endproperty
    a_restart_first: assert property (p_restart_first) else $error("Restart missed.");

    // A NACK must not mark the endpoint busy, or the following tokens would go unanswered.
    property p_nak_not_busy;
        @(posedge clk_i) disable iff (rst_i)
        (reply_o == IED_NAK) |-> !busy_r;
    endproperty
    a_nak_not_busy: assert property (p_nak_not_busy) else $error("NACK left busy set.");
endmodule // ied_desc

// File: verif/ied_host_model.sv
// Far-side model: issues in tokens and acknowledges each data packet after a lag.
`timescale 1ns/1ps
module ied_host_model
    import ied_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [3:0] lag_i,
    input  wire ied_reply_t reply_i,
    output logic            in_token_o,
    output logic            in_done_o
);
    logic [3:0] cnt_r;
    logic       wait_r;
    // Only a sent packet is acknowledged; a NACK leaves the host with nothing to acknowledge.
    always_ff @(posedge clk_i) begin
        in_token_o <= go_i && !rst_i;
        in_done_o  <= 1'b0;
        if (rst_i) begin
            wait_r <= 1'b0;
        end else if (reply_i == IED_SEND) begin
            wait_r <= 1'b1;
            cnt_r  <= lag_i;
        end else if (wait_r && cnt_r == 4'h0) begin
            in_done_o <= 1'b1;
            wait_r    <= 1'b0;
        end else if (wait_r) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule // ied_host_model

// File: verif/testbench.sv
// Self-checking bench for the in endpoint descriptor.
`timescale 1ns/1ps
module testbench
    import ied_pkg::*;
;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, in_token, in_done, go;
    logic [7:0]  wb_adr, len_f, yb;
    logic [6:0]  cx, cy;
    logic [3:0]  wb_sel, lag;
    logic [31:0] wb_wdat, wb_rdat;
    logic [10:0] fstart;
    logic [4:0]  bps;
    ied_reply_t  reply;
    ied_send_t   send;
    logic [38:0] tx_q[$];
    logic [31:0] rd_q[$];
    int          fails, cmp_count, seed;
    ied_desc u_ied_desc (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .in_token_i(in_token), .in_done_i(in_done),
        .first_buffer_start_i(fstart), .buffer_length_field_i(len_f),
        .sample_size_field_i(bps), .reply_o(reply), .send_o(send));
    ied_host_model u_ied_host_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .lag_i(lag),
        .reply_i(reply), .in_token_o(in_token), .in_done_o(in_done));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // A read notes its expected data; a write only waits for the acknowledge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w) rd_q.push_back(d);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, w, a, 4'hf, d};
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        {wb_cyc, wb_stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic tok(input logic [38:0] e);
        tx_q.push_back(e);
        lag <= 4'($random(seed));
        go  <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (24) @(posedge clk_i);
    endtask
    function automatic logic [38:0] sx(input logic s, input logic [12:0] b, input logic [10:0] a);
        return {IED_SEND, 1'b1, s, b, a, len_f, 3'h0};
    endfunction
    always @(posedge clk_i) begin : watch
        logic [38:0] e;
        if (wb_ack === 1'b1 && wb_we === 1'b0) chk(wb_rdat, rd_q.pop_front());
        if (!rst_i && reply !== IED_IDLE) begin
            e = tx_q.size() > 0 ? tx_q.pop_front() : 39'h0;
            if (e[38:37] == IED_NAK) chk({reply, send.valid}, {e[38:37], 1'b0});
            else chk({reply, send}, e);
        end
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        end_of_test;
    end
    initial begin
        seed = 32'h419ee6cb;
        {rst_i, wb_cyc, wb_stb, wb_we, go, wb_adr, wb_wdat, wb_sel, lag} = {5'b10000, 40'h0, 8'h1};
        {fstart, len_f, bps} = 24'($random(seed));
        {cx, cy, yb} = 22'($random(seed));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h00, 32'h80);
        bus(1'b0, 8'h04, 32'h0);
        bus(1'b0, 8'h08, 32'h80);
        bus(1'b1, 8'h0c, 32'h80);
        tok({IED_NAK, 37'h0});
        bus(1'b1, 8'h08, {25'h0, cx});
        tok(sx(1'b0, {6'h0, cx}, fstart));
        bus(1'b0, 8'h08, {24'h0, 1'b1, cx});
        tok({IED_NAK, 37'h0});
        bus(1'b1, 8'h14, 32'hff);
        bus(1'b0, 8'h14, 32'h0);
        bus(1'b1, 8'h04, {24'h0, yb});
        bus(1'b0, 8'h04, {24'h0, yb});
        // The first buffer keeps its flag from the last packet: isochronous sends regardless.
        bus(1'b1, 8'h00, {25'h0, cy});
        bus(1'b1, 8'h0c, 32'h0);
        bus(1'b1, 8'h0c, 32'he0);
        tok(sx(1'b0, cx * (bps + 13'h1), fstart));
        bus(1'b0, 8'h10, 32'h1);
        tok(sx(1'b1, cy * (bps + 13'h1), {yb, 3'h0}));
        bus(1'b0, 8'h00, {24'h0, 1'b1, cy});
        tok(sx(1'b0, cx * (bps + 13'h1), fstart));
        end_of_test;
    end
endmodule // testbench
